//--- rtl/iiec_params.svh
// Offsets, field positions, reset values and counts of the block
`ifndef IIEC_PARAMS_SVH
`define IIEC_PARAMS_SVH
// Register byte offsets
`define IIEC_OFS_IEAC 8'h00
`define IIEC_OFS_STAT 8'h04
`define IIEC_OFS_MASK 8'h08
// Enable and acknowledge register fields
`define IIEC_TIE 7
`define IIEC_TX_END_IRQ_EN 6
`define IIEC_RIE 5
`define IIEC_NOACK_IRQ_EN 4
`define IIEC_STOP_DETECT_IRQ_EN 3
`define IIEC_ACK_CHECK_SEL 2
`define IIEC_ACK_RECEIVED 1
`define IIEC_ACK_TO_SEND 0
// Write mask keeps the captured acknowledge bit read-only
`define IIEC_IEAC_WMASK 8'hFD
// Status register fields, mask register uses the same layout
`define IIEC_TX_BUF_EMPTY_FLAG 7
`define IIEC_TX_END_FLAG 6
`define IIEC_RX_BUF_FULL_FLAG 5
`define IIEC_NOACK_FLAG 4
`define IIEC_STOP 3
`define IIEC_AL 2
`define IIEC_STAT_LO 2
// Reset values
`define IIEC_IEAC_RST 8'h00
`define IIEC_STAT_RST 8'h00
`define IIEC_MASK_RST 8'h00
// Data bits before the acknowledge slot
`define IIEC_DATA_BITS 4'h8
`endif

//--- rtl/iiec_pkg.sv
// Types shared by the acknowledge and interrupt control block
package iiec_pkg;
   // Frame slot tracker, one-hot
   typedef enum logic [3:0] {
      IIEC_IDLE = 4'b0001,
      IIEC_DATA = 4'b0010,
      IIEC_ACK = 4'b0100,
      IIEC_HALT = 4'b1000
   } iiec_slot_t;
endpackage : iiec_pkg

//--- rtl/iiec_sync.sv
// Two-flop synchroniser for the serial bus pins
`timescale 1ns/1ns
module iiec_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] in_async,
   output logic [1:0] out_sync
);
   // First stage, read only by the second
   logic [1:0] meta;

   // Both stages reset high like an idle bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 2'h3;
         out_sync <= 2'h3;
      end else begin
         meta <= in_async;
         out_sync <= meta;
      end
   end
endmodule : iiec_sync

//--- rtl/iiec_ctrl.sv
// Interrupt enable and acknowledge control of the two-wire interface
// Notes on behaviour
// - Tx empty request needs flag and enable
// - Tx end request gated by its enable
// - Tx end request drops with flag/enable
// - Rx full request gated by its enable
// - Rx full request drops with flag/enable
// - Noack enable gates noack or arb-lost
// - Noack request drops with flags/enable
// - Stop request only while its enable set
// - Check off: ignore acknowledge, keep going
// - Check on, transmitting, acknowledge one: halt transfer
// - Transmit mode captures acknowledge, read-only
// - Receive mode drives chosen acknowledge value
// - Tx end set at ninth rise, empty
// - Noack flag only when checking, transmitting
// - Tx empty set on buffer-to-shift move
`timescale 1ns/1ns
`include "iiec_params.svh"
module iiec_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic tx_mode,
   input wire logic frame_start,
   input wire logic tx_load_evt,
   input wire logic rx_load_evt,
   input wire logic stop_evt,
   input wire logic arb_lost_evt,
   input wire logic tx_buf_write,
   input wire logic rx_buf_read,
   output logic sda_o,
   output logic sda_oe,
   output logic xfer_halt,
   output logic tx_empty_irq,
   output logic tx_end_irq,
   output logic rx_full_irq,
   output logic noack_irq,
   output logic stop_detect_irq,
   output logic irq
);
   logic [7:0] ien; // Enable and acknowledge control, bit 1 unused
   logic ack_received; // Captured acknowledge from the receiver
   logic [7:0] stat; // Sticky status flags
   localparam logic [7:0] stat_rst_val = `IIEC_STAT_RST; // Flag reset
   logic [7:0] mask; // Interrupt mask, same layout as status
   // Per-bit set and clear terms of the status flags
   logic [7:0] st_set;
   logic [7:0] st_clr;
   // Synchronised pins and edge history
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_d;
   logic scl_rise;
   logic scl_fall;
   // Frame slot state and bit count
   iiec_pkg::iiec_slot_t state;
   iiec_pkg::iiec_slot_t next_state;
   logic [3:0] bit_cnt;
   // Ninth rising edge and no-acknowledge detection
   logic ack_rise;
   logic nack_det;
   // Bus access decode
   logic acc;
   logic wr;
   logic map_hit;
   logic [7:0] rd_val;

   // Pin synchroniser
   iiec_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .in_async({scl_pin, sda_pin}),
      .out_sync(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Edge detection on the synchronised clock line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
      end
   end
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;

   // Access phase of an APB transfer, answered at once
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign map_hit = (paddr == `IIEC_OFS_IEAC) ||
                    (paddr == `IIEC_OFS_STAT) ||
                    (paddr == `IIEC_OFS_MASK);

   // Read mux, captured acknowledge placed in bit 1
   always_comb begin
      case (paddr)
         `IIEC_OFS_IEAC: begin
            rd_val = ien;
            rd_val[`IIEC_ACK_RECEIVED] = ack_received;
         end
         `IIEC_OFS_STAT: rd_val = stat;
         `IIEC_OFS_MASK: rd_val = mask;
         default: rd_val = 8'h00;
      endcase
   end

   // Bus answer: ready, error and read data registered in the setup cycle, shown in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~map_hit;
         prdata <= {24'h000000, rd_val};
      end
   end

   // Enable and acknowledge control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien <= `IIEC_IEAC_RST;
      end else if (wr && paddr == `IIEC_OFS_IEAC) begin
         ien <= pwdata[7:0] & `IIEC_IEAC_WMASK;
      end
   end

   // Interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= `IIEC_MASK_RST;
      end else if (wr && paddr == `IIEC_OFS_MASK) begin
         mask <= pwdata[7:0];
      end
   end

   // Slot sequencing of a frame
   always_comb begin
      case (state)
         iiec_pkg::IIEC_IDLE: next_state = state;
         iiec_pkg::IIEC_DATA: begin
            // Eight data bits done, acknowledge slot follows
            if (scl_fall && bit_cnt == `IIEC_DATA_BITS) begin
               next_state = iiec_pkg::IIEC_ACK;
            end else begin
               next_state = state;
            end
         end
         iiec_pkg::IIEC_ACK: begin
            // End of ninth clock: halt or next frame
            if (scl_fall) begin
               next_state = xfer_halt ? iiec_pkg::IIEC_HALT
                                      : iiec_pkg::IIEC_DATA;
            end else begin
               next_state = state;
            end
         end
         iiec_pkg::IIEC_HALT: next_state = state;
         default: next_state = iiec_pkg::IIEC_IDLE;
      endcase
      // Start and stop override the sequence
      if (frame_start) begin
         next_state = iiec_pkg::IIEC_DATA;
      end else if (stop_evt) begin
         next_state = iiec_pkg::IIEC_IDLE;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= iiec_pkg::IIEC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Data bit counter, cleared on each new frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 4'h0;
      end else if (frame_start || next_state != iiec_pkg::IIEC_DATA ||
                   state != iiec_pkg::IIEC_DATA) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Ninth rising edge and a missing acknowledge while checking in transmit mode
   assign ack_rise = (state == iiec_pkg::IIEC_ACK) & scl_rise;
   assign nack_det = ack_rise & tx_mode & ien[`IIEC_ACK_CHECK_SEL] & sda_s;

   // Captured acknowledge in transmit mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_received <= 1'b0;
      end else if (ack_rise && tx_mode) begin
         ack_received <= sda_s;
      end
   end

   // Halt of continuous transfer on a checked acknowledge of one in transmit mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_halt <= 1'b0;
      end else if (frame_start || stop_evt) begin
         xfer_halt <= 1'b0;
      end else if (nack_det) begin
         xfer_halt <= 1'b1;
      end
   end

   // Acknowledge drive in receive mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_oe <= 1'b0;
         sda_o <= 1'b1;
      end else begin
         sda_oe <= (state == iiec_pkg::IIEC_ACK) & ~tx_mode;
         sda_o <= ien[`IIEC_ACK_TO_SEND];
      end
   end

   // Status flag set terms
   always_comb begin
      st_set = 8'h00;
      st_set[`IIEC_TX_BUF_EMPTY_FLAG] = tx_load_evt;
      st_set[`IIEC_TX_END_FLAG] = ack_rise & stat[`IIEC_TX_BUF_EMPTY_FLAG];
      st_set[`IIEC_RX_BUF_FULL_FLAG] = rx_load_evt;
      st_set[`IIEC_NOACK_FLAG] = nack_det;
      st_set[`IIEC_STOP] = stop_evt;
      st_set[`IIEC_AL] = arb_lost_evt;
   end

   // Status flag clear terms: write one, buffer accesses
   always_comb begin
      st_clr = 8'h00;
      if (wr && paddr == `IIEC_OFS_STAT) begin
         st_clr = pwdata[7:0];
      end
      if (tx_buf_write) begin
         st_clr[`IIEC_TX_BUF_EMPTY_FLAG] = 1'b1;
         st_clr[`IIEC_TX_END_FLAG] = 1'b1;
      end
      if (rx_buf_read) begin
         st_clr[`IIEC_RX_BUF_FULL_FLAG] = 1'b1;
      end
   end

   // Sticky flags, a set wins over a clear in the same cycle
   for (genvar b = 0; b < 8; b++) begin : g_stat
      if (b >= `IIEC_STAT_LO) begin : g_flag
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat[b] <= stat_rst_val[b];
            end else begin
               stat[b] <= st_set[b] | (stat[b] & ~st_clr[b]);
            end
         end
      end else begin : g_zero
         assign stat[b] = 1'b0;
      end
   end

   // Interrupt requests, each a flag (noack: noack or arb-lost flag) gated by its enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_empty_irq <= 1'b0;
         tx_end_irq <= 1'b0;
         rx_full_irq <= 1'b0;
         noack_irq <= 1'b0;
         stop_detect_irq <= 1'b0;
      end else begin
         tx_empty_irq <= stat[`IIEC_TX_BUF_EMPTY_FLAG] & ien[`IIEC_TIE];
         tx_end_irq <= stat[`IIEC_TX_END_FLAG] & ien[`IIEC_TX_END_IRQ_EN];
         rx_full_irq <= stat[`IIEC_RX_BUF_FULL_FLAG] & ien[`IIEC_RIE];
         noack_irq <= (stat[`IIEC_NOACK_FLAG] | stat[`IIEC_AL]) &
                      ien[`IIEC_NOACK_IRQ_EN];
         stop_detect_irq <= stat[`IIEC_STOP] & ien[`IIEC_STOP_DETECT_IRQ_EN];
      end
   end

   // Summary interrupt from unmasked status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat & mask);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Receive data arrival through to the request
   sequence s_rx_arrive;
      rx_load_evt && ien[`IIEC_RIE] && !rx_buf_read;
   endsequence
   sequence s_ack_one;
      ack_rise && tx_mode && ien[`IIEC_ACK_CHECK_SEL] && sda_s;
   endsequence
   property p_tx_empty;
      stat[`IIEC_TX_BUF_EMPTY_FLAG] && ien[`IIEC_TIE] |=> tx_empty_irq;
   endproperty
   a_tx_empty: assert property (p_tx_empty)
      else $error("tx empty request missing");
   property p_tx_end_drop;
      !stat[`IIEC_TX_END_FLAG] || !ien[`IIEC_TX_END_IRQ_EN] |=> !tx_end_irq;
   endproperty
   a_tx_end_drop: assert property (p_tx_end_drop)
      else $error("tx end request not withdrawn");
   property p_tx_end_flag_set;
      ack_rise && stat[`IIEC_TX_BUF_EMPTY_FLAG] |=> stat[`IIEC_TX_END_FLAG] ##1
         tx_end_irq == $past(ien[`IIEC_TX_END_IRQ_EN]);
   endproperty
   a_tx_end_flag_set: assert property (p_tx_end_flag_set)
      else $error("tx end flag not set at ninth rise");
   property p_rx_full;
      s_rx_arrive ##1 ien[`IIEC_RIE] && !rx_buf_read |=> rx_full_irq;
   endproperty
   a_rx_full: assert property (p_rx_full)
      else $error("rx full request missing");
   property p_noack_drop;
      !(stat[`IIEC_NOACK_FLAG] || stat[`IIEC_AL]) |=> !noack_irq;
   endproperty
   a_noack_drop: assert property (p_noack_drop)
      else $error("noack request not withdrawn");
   property p_stop_off;
      !ien[`IIEC_STOP_DETECT_IRQ_EN] |=> !stop_detect_irq;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("stop request while disabled");
   property p_ack_halt;
      s_ack_one ##0 !frame_start && !stop_evt |=>
         xfer_halt && stat[`IIEC_NOACK_FLAG];
   endproperty
   a_ack_halt: assert property (p_ack_halt)
      else $error("checked acknowledge did not halt");
   property p_ack_ignored;
      ack_rise && !ien[`IIEC_ACK_CHECK_SEL] |=> !stat[`IIEC_NOACK_FLAG] ||
         $past(stat[`IIEC_NOACK_FLAG]);
   endproperty
   a_ack_ignored: assert property (p_ack_ignored)
      else $error("acknowledge not ignored");
   property p_ack_capture;
      ack_rise && tx_mode |=> ack_received == $past(sda_s);
   endproperty
   a_ack_capture: assert property (p_ack_capture)
      else $error("acknowledge not captured");
   property p_ack_drive;
      state == iiec_pkg::IIEC_ACK && !tx_mode |=>
         sda_oe && sda_o == $past(ien[`IIEC_ACK_TO_SEND]);
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("acknowledge not driven");
endmodule : iiec_ctrl

//--- dv/iiec_peer.sv
// Far-side bus device: makes frames on the serial clock and answers
`timescale 1ns/1ns
module iiec_peer (
   input wire logic go,
   input wire logic dev_tx,
   input wire logic ack_val,
   input wire logic [7:0] data,
   output logic scl,
   output logic sda_o,
   output logic sda_oe,
   output logic busy
);
   // Clock idles high; data and acknowledge change while it is low
   initial begin
      scl = 1'b1;
      sda_o = 1'b0;
      sda_oe = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge go);
         busy = 1'b1;
         #437 scl = 1'b0;
         for (int i = 0; i < 8; i++) begin
            sda_oe = !dev_tx; // Sends data when the device receives
            sda_o = data[7 - i];
            #400 scl = 1'b1;
            #400 scl = 1'b0;
         end
         sda_oe = dev_tx; // Answers when the device sends
         sda_o = ack_val;
         #400 scl = 1'b1;
         #400 scl = 1'b0;
         sda_oe = 1'b0; // Released, pull-up takes the line
         #400 scl = 1'b1;
         busy = 1'b0;
      end
   end
endmodule : iiec_peer

//--- dv/tb_top.sv
// Self-checking bench of the acknowledge and interrupt control block
`timescale 1ns/1ns
`include "iiec_params.svh"
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, lf = 32'h8B417F9A;
   logic pready, pslverr, tx_mode = 1'b1, go = 0, ack = 0, obs = 0;
   logic [6:0] pl = 7'h00; // Event pulses
   logic sda_o, sda_oe, p_oe, p_o, scl, busy, oe_d = 0, hit;
   logic halt, i_te, i_tn, i_rf, i_na, i_st, irq;
   logic [32:0] exp_q[$];
   logic [32:0] got;
   logic [7:0] st[4] = '{8'h80, 8'h20, 8'h04, 8'h08}; // Status bits
   logic [7:0] en[4] = '{8'h80, 8'h20, 8'h10, 8'h08}; // Enable bits
   logic [7:0] ln[4] = '{8'h40, 8'h10, 8'h08, 8'h04}; // Request lines
   logic e, a;
   int n_errors = 0, cmp_count = 0;
   wire sda = ~((p_oe & ~p_o) | (sda_oe & ~sda_o)); // Open drain
   always #50 pclk = ~pclk;
   iiec_ctrl i_iiec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_pin(scl), .sda_pin(sda), .tx_mode(tx_mode),
      .frame_start(pl[5]), .tx_load_evt(pl[0]), .rx_load_evt(pl[1]),
      .stop_evt(pl[3]), .arb_lost_evt(pl[2]), .tx_buf_write(pl[4]),
      .rx_buf_read(pl[6]), .sda_o(sda_o), .sda_oe(sda_oe),
      .xfer_halt(halt), .tx_empty_irq(i_te), .tx_end_irq(i_tn),
      .rx_full_irq(i_rf), .noack_irq(i_na), .stop_detect_irq(i_st),
      .irq(irq));
   iiec_peer i_iiec_peer (.go(go), .dev_tx(tx_mode), .ack_val(ack),
      .data(lf[7:0]), .scl(scl), .sda_o(p_o), .sda_oe(p_oe), .busy(busy));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task tally_and_finish;
      if (exp_q.size() != 0) n_errors++;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   // Watcher takes the oldest note whenever a result shows
   always @(posedge pclk) begin
      hit = 1'b1;
      if (psel && penable && pready && !pwrite) got = {pslverr, prdata};
      else if (obs) got = {25'h0, irq, i_te, i_tn, i_rf, i_na, i_st,
         halt, 1'b0};
      else if (sda_oe && !oe_d) got = {32'h0, sda_o};
      else hit = 1'b0;
      oe_d <= sda_oe;
      if (hit) begin
         cmp_count++;
         if (exp_q.size() == 0 || got !== exp_q[0]) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
               exp_q[0]);
         end
         if (exp_q.size() != 0) exp_q.pop_front();
      end
   end
   // One bus transfer, held until the ready edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits for ready; a hang is ended by the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask : wr
   task rd(input logic [7:0] ad, input logic [32:0] x);
      exp_q.push_back(x);
      apb(1'b0, ad, 32'h0);
   endtask : rd
   // Looks at the request lines once they have settled
   task chk(input logic [7:0] x);
      exp_q.push_back({25'h0, x});
      repeat (3) @(posedge pclk);
      obs <= 1'b1;
      @(posedge pclk);
      obs <= 1'b0;
   endtask : chk
   task pulse(input logic [6:0] v);
      @(posedge pclk);
      pl <= v;
      @(posedge pclk);
      pl <= 7'h00;
   endtask : pulse
   task frame(input logic t, input logic v);
      @(posedge pclk);
      tx_mode <= t;
      ack <= v;
      pulse(7'h20);
      @(posedge pclk) go <= 1'b1;
      @(posedge pclk) go <= 1'b0;
      while (busy) begin
         @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask : frame
   initial begin
      #300000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`IIEC_OFS_IEAC, 33'h0);
      rd(`IIEC_OFS_STAT, 33'h0);
      rd(8'h0C, 33'h100000000);
      wr(`IIEC_OFS_IEAC, 32'hFF);
      rd(`IIEC_OFS_IEAC, 33'hFD);
      lf = lfsr(lf);
      wr(`IIEC_OFS_IEAC, lf);
      rd(`IIEC_OFS_IEAC, {25'h0, lf[7:0] & 8'hFD});
      wr(`IIEC_OFS_IEAC, 32'h0);
      $display("registers test done");
      for (int k = 0; k < 4; k++) begin
         pulse(7'h01 << k);
         rd(`IIEC_OFS_STAT, {25'h0, st[k]});
         chk(8'h00);
         wr(`IIEC_OFS_IEAC, {24'h0, en[k]});
         chk(ln[k]);
         wr(`IIEC_OFS_MASK, {24'h0, st[k]});
         chk(ln[k] | 8'h80);
         wr(`IIEC_OFS_IEAC, 32'h0);
         chk(8'h80);
         wr(`IIEC_OFS_IEAC, {24'h0, en[k]});
         wr(`IIEC_OFS_STAT, {24'h0, st[k]});
         chk(8'h00);
         wr(`IIEC_OFS_MASK, 32'h0);
      end
      wr(`IIEC_OFS_IEAC, 32'h20);
      pulse(7'h02);
      chk(8'h10);
      pulse(7'h40);
      chk(8'h00);
      rd(`IIEC_OFS_STAT, 33'h0);
      $display("interrupt test done");
      for (int k = 0; k < 3; k++) begin
         e = (k != 1);
         a = (k != 2);
         wr(`IIEC_OFS_IEAC, {29'h0, e, 2'h0} | 32'h50);
         pulse(7'h01);
         frame(1'b1, a);
         rd(`IIEC_OFS_IEAC, {25'h0, 8'h50 | {5'h0, e, a, 1'b0}});
         rd(`IIEC_OFS_STAT, {25'h0, 8'hC0 | {3'h0, e & a, 4'h0}});
         chk({2'h0, 1'b1, 1'b0, e & a, 1'b0, e & a, 1'b0});
         pulse(7'h10);
         chk({4'h0, e & a, 1'b0, e & a, 1'b0});
         pulse(7'h08);
         wr(`IIEC_OFS_STAT, 32'hFF);
      end
      $display("transmit test done");
      for (int k = 0; k < 2; k++) begin
         wr(`IIEC_OFS_IEAC, {31'h0, k[0]});
         exp_q.push_back({32'h0, k[0]});
         lf = lfsr(lf);
         frame(1'b0, 1'b1);
      end
      $display("receive test done");
      tally_and_finish;
   end
endmodule : tb_top
